// file: design/host_adapter.sv
`timescale 1ns/1ps

// Behaviour
// R1 - selected quiet state keeps interrupt low
// R2 - selected irq state holds interrupt high
// R3 - flagged content, enabled: set pending, raise
// R4 - devctl write no reset, pending, enabled: frame, stay
// R5 - devctl reset: busy, clear pending, frame, quiet
// R6 - command write: busy, clear pending, frame C1
// R7 - device write selecting drive 1: not-selected
// R8 - status read clears pending, goes quiet
// R9 - other accesses leave irq state alone
// R10 - transport content loads shadows, stays irq
// R11 - not-selected keeps interrupt low
// R12 - comreset: busy, drive 0, clear pending
// R13 - devctl no reset: frame C0, stay
// R14 - devctl reset: busy, drive 0, frame, quiet
// R15 - other commands ignored while not-selected
// R16 - diagnostic: busy, drive 0, frame C1
// R17 - device write drive 0 picks selected state
// R18 - other writes only load shadows while not-selected
// R19 - status reads 00h, others read shadows
// R20 - transport content loads shadows, stays
// R21 - drive reports pending via irq flag
// R22 - sent frames carry interrupt disable zero
// R23 - reset: quiet state, pending clear
// R24 - interrupt registered from next-state decode
module host_adapter
	import host_adapter_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// transport and link side
	input wire d2h_reg_s d2h_i,
	output h2d_req_s h2d_o,
	output logic comreset_o,
	// host interrupt
	output logic host_interrupt_line_o
);

	adapter_state_e state;
	adapter_state_e next_state;
	shadow_s shadow;
	logic irq_pending_flag;
	logic next_pending;
	logic access;
	logic wr;
	logic rd;
	logic [7:0] wbyte;
	logic mapped;
	logic [7:0] read_byte;

	////////////////////////////////////////////////////////////////////////
	// bus decode: every access completes in its first access cycle

	assign access = psel_i && penable_i;
	assign wr = access && pwrite_i;
	assign rd = access && !pwrite_i;
	assign wbyte = pwdata_i[7:0];

	always_comb begin
		mapped = 1'b1;
		read_byte = zero_byte;
		case (paddr_i)
			off_error_features: read_byte = shadow.error;
			off_sector_count: read_byte = shadow.sector_count;
			off_lba_low: read_byte = shadow.lba_low;
			off_lba_mid: read_byte = shadow.lba_mid;
			off_lba_high: read_byte = shadow.lba_high;
			off_device: read_byte = shadow.device;
			off_status_command: read_byte = shadow.status;
			off_altstat_devctl: read_byte = shadow.status;
			off_adapter_state: read_byte = {5'h00, irq_pending_flag, state};
			off_data, off_comreset: read_byte = zero_byte;
			default: mapped = 1'b0;
		endcase
		// status and alternate status hide the other drive
		if (state == other_drive_state && (paddr_i == off_status_command ||
			paddr_i == off_altstat_devctl)) begin
			read_byte = not_selected_status; // [R19]
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !mapped;
			if (psel_i && !penable_i && !pwrite_i) begin
				prdata_o <= {24'h00_0000, read_byte}; // [R19]
			end
		end
	end

	// the access phase completes one cycle after setup, on pready
	logic done;
	logic dc_wr;
	logic cmd_wr;
	logic dev_wr;
	logic cr_wr;
	logic stat_rd;
	logic other_acc;
	assign done = access && pready_o && mapped;
	assign dc_wr = done && pwrite_i && paddr_i == off_altstat_devctl;
	assign cmd_wr = done && pwrite_i && paddr_i == off_status_command;
	assign dev_wr = done && pwrite_i && paddr_i == off_device;
	assign cr_wr = done && pwrite_i && paddr_i == off_comreset;
	assign stat_rd = done && rd && paddr_i == off_status_command;
	assign other_acc = done && !dc_wr && !cmd_wr && !dev_wr && !cr_wr &&
		!stat_rd;

	////////////////////////////////////////////////////////////////////////
	// adapter state machine; mapped host accesses, except status reads outside the irq state, take
	// priority over transport content arriving in the same cycle, which is then applied to shadows

	logic dc_interrupt_disable_bit;
	logic dc_soft_reset_bit;
	logic sel_one;
	assign dc_interrupt_disable_bit = wbyte[interrupt_disable_pos];
	assign dc_soft_reset_bit = wbyte[soft_reset_pos];
	assign sel_one = wbyte[drive_select_pos];

	always_comb begin
		next_state = state;
		next_pending = irq_pending_flag;
		if (cr_wr) begin
			next_state = selected_quiet_state; // [R12]
			next_pending = 1'b0;
		end else if (dc_wr && dc_soft_reset_bit) begin
			next_state = selected_quiet_state; // [R5] [R14]
			next_pending = 1'b0;
		end else if (dc_wr) begin
			if (state != other_drive_state) begin
				// irq state only survives with interrupts enabled; pending is kept either way
				next_state = (!dc_interrupt_disable_bit && irq_pending_flag) ?
					selected_irq_state : selected_quiet_state; // [R4]
			end
		end else if (cmd_wr) begin
			if (state != other_drive_state || wbyte == exec_diag_code) begin
				next_state = selected_quiet_state; // [R6] [R16]
				next_pending = 1'b0;
			end
		end else if (dev_wr) begin
			if (sel_one) begin
				next_state = other_drive_state; // [R7]
			end else if (state == other_drive_state) begin
				next_state = (!shadow.control[interrupt_disable_pos] &&
					irq_pending_flag) ? selected_irq_state :
					selected_quiet_state; // [R17]
			end
		end else if (stat_rd && state == selected_irq_state) begin
			next_state = selected_quiet_state; // [R8]
			next_pending = 1'b0;
		end else if (other_acc) begin
			next_state = state; // [R9] [R18]
		end else if (d2h_i.valid && d2h_i.irq_flag &&
			state != other_drive_state) begin
			next_pending = 1'b1; // [R3]
			if (!shadow.control[interrupt_disable_pos]) begin
				next_state = selected_irq_state; // [R3]
			end
		end else if (d2h_i.valid && d2h_i.irq_flag) begin
			next_pending = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= selected_quiet_state; // [R23]
			irq_pending_flag <= 1'b0;
		end else begin
			state <= next_state;
			irq_pending_flag <= next_pending;
		end
	end

	// interrupt registered from the next-state decode, in step with the state register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			host_interrupt_line_o <= 1'b0; // [R23]
		end else begin
			host_interrupt_line_o <= next_state == selected_irq_state; // [R24]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shadow blocks

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shadow <= '0;
			shadow.status <= status_reset_value;
		end else begin
			if (d2h_i.valid) begin
				shadow.error <= d2h_i.error; // [R10] [R20]
				shadow.sector_count <= d2h_i.sector_count;
				shadow.lba_low <= d2h_i.lba_low;
				shadow.lba_mid <= d2h_i.lba_mid;
				shadow.lba_high <= d2h_i.lba_high;
				shadow.device <= d2h_i.device;
				shadow.status <= d2h_i.status;
			end
			if (done && pwrite_i) begin
				case (paddr_i)
					off_error_features: shadow.features <= wbyte;
					off_sector_count: shadow.sector_count <= wbyte;
					off_lba_low: shadow.lba_low <= wbyte;
					off_lba_mid: shadow.lba_mid <= wbyte;
					off_lba_high: shadow.lba_high <= wbyte;
					off_device: shadow.device <= wbyte;
					off_altstat_devctl: shadow.control <= wbyte;
					off_status_command: begin
						if (state != other_drive_state ||
							wbyte == exec_diag_code) begin
							shadow.command <= wbyte;
						end
					end
					default: shadow.control <= shadow.control;
				endcase
			end
			if (cr_wr || (dc_wr && dc_soft_reset_bit) || (cmd_wr &&
				(state != other_drive_state || wbyte == exec_diag_code))) begin
				shadow.status[busy_status_pos] <= 1'b1; // [R5] [R6] [R12]
			end
			if ((state == other_drive_state) && (cr_wr ||
				(dc_wr && dc_soft_reset_bit) || (cmd_wr && wbyte == exec_diag_code))) begin
				shadow.device[drive_select_pos] <= 1'b0; // [R12] [R14] [R16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outgoing frame and comreset requests, one-cycle pulses

	shadow_s frame_blocks;
	always_comb begin
		frame_blocks = shadow;
		if (dc_wr) begin
			frame_blocks.control = wbyte;
		end
		if (cmd_wr) begin
			frame_blocks.command = wbyte;
		end
		// a plain devctl frame while not-selected carries the shadows as-is
		if (state == other_drive_state && !(dc_wr && !dc_soft_reset_bit)) begin
			frame_blocks.device[drive_select_pos] = 1'b0;
		end
		frame_blocks.control[interrupt_disable_pos] = 1'b0; // [R22]
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			h2d_o <= '0;
			comreset_o <= 1'b0;
		end else begin
			comreset_o <= cr_wr; // [R12]
			h2d_o.blocks <= frame_blocks;
			h2d_o.valid <= dc_wr || (cmd_wr && (state != other_drive_state ||
				wbyte == exec_diag_code)); // [R13] [R15]
			h2d_o.command_flag <= cmd_wr; // [R6] [R16]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	not_sel_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state != selected_irq_state |=> !host_interrupt_line_o || state ==
		selected_irq_state) else $error("interrupt outside irq state"); // [R11]
	irq_held_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state == selected_irq_state |-> host_interrupt_line_o)
		else $error("interrupt low in irq state"); // [R2]
	dev_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dev_wr && sel_one |=> state == other_drive_state && !h2d_o.valid)
		else $error("drive 1 select failed"); // [R7]
	status_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		stat_rd && state == selected_irq_state && !cr_wr |=>
		!irq_pending_flag && !host_interrupt_line_o)
		else $error("status read kept interrupt"); // [R8]
	cmd_frame_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cmd_wr && state != other_drive_state |=> h2d_o.valid &&
		h2d_o.command_flag && shadow.status[busy_status_pos])
		else $error("command frame missing"); // [R6]
	soft_reset_bit_frame_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dc_wr && dc_soft_reset_bit |=> h2d_o.valid && !h2d_o.command_flag &&
		state == selected_quiet_state && !irq_pending_flag)
		else $error("soft reset handling wrong"); // [R14]
	interrupt_disable_bit_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		h2d_o.valid |-> !h2d_o.blocks.control[interrupt_disable_pos])
		else $error("frame sent with interrupt disable"); // [R22]
	comreset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cr_wr |=> comreset_o && state == selected_quiet_state &&
		!irq_pending_flag) else $error("comreset handling wrong"); // [R12]
	notsel_cmd_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cmd_wr && state == other_drive_state && wbyte != exec_diag_code |=>
		!h2d_o.valid && state == other_drive_state)
		else $error("ignored command acted"); // [R15]

	// quiet and not-selected states never show an interrupt
	quiet_low_a: assert property (@(posedge ref_clk_i) // [R1]
		disable iff (rst_i)
		state == selected_quiet_state |-> !host_interrupt_line_o)
		else $error("interrupt high in quiet state");
	other_low_a: assert property (@(posedge ref_clk_i) // [R11]
		disable iff (rst_i)
		state == other_drive_state |-> !host_interrupt_line_o)
		else $error("interrupt high while not selected");
	masked_flag_a: assert property (@(posedge ref_clk_i) // [R1]
		disable iff (rst_i)
		d2h_i.valid && d2h_i.irq_flag && !done &&
		state == selected_quiet_state &&
		shadow.control[interrupt_disable_pos] |=>
		state == selected_quiet_state && irq_pending_flag)
		else $error("masked flag handled wrong");
	flag_raise_a: assert property (@(posedge ref_clk_i) // [R3]
		disable iff (rst_i)
		d2h_i.valid && d2h_i.irq_flag && !done &&
		state == selected_quiet_state &&
		!shadow.control[interrupt_disable_pos] |=>
		state == selected_irq_state && irq_pending_flag)
		else $error("flagged content did not raise");
	devctl_keep_a: assert property (@(posedge ref_clk_i) // [R4]
		disable iff (rst_i)
		dc_wr && !dc_soft_reset_bit && !dc_interrupt_disable_bit && irq_pending_flag &&
		state == selected_irq_state |=> state == selected_irq_state &&
		h2d_o.valid && !h2d_o.command_flag)
		else $error("devctl write left irq state");
	soft_reset_bit_busy_a: assert property (@(posedge ref_clk_i) // [R5]
		disable iff (rst_i)
		dc_wr && dc_soft_reset_bit |=> shadow.status[busy_status_pos])
		else $error("soft reset did not set busy");
	irq_other_a: assert property (@(posedge ref_clk_i) // [R9]
		disable iff (rst_i)
		other_acc && state == selected_irq_state |=>
		state == selected_irq_state && irq_pending_flag)
		else $error("other access changed irq state");
	irq_load_a: assert property (@(posedge ref_clk_i) // [R10]
		disable iff (rst_i)
		d2h_i.valid && !done && state == selected_irq_state |=>
		state == selected_irq_state &&
		shadow.error == $past(d2h_i.error))
		else $error("content not loaded in irq state");
	other_load_a: assert property (@(posedge ref_clk_i) // [R20]
		disable iff (rst_i)
		d2h_i.valid && !done && state == other_drive_state |=>
		state == other_drive_state &&
		shadow.lba_mid == $past(d2h_i.lba_mid))
		else $error("content not loaded while not selected");
	notsel_dc_a: assert property (@(posedge ref_clk_i) // [R13]
		disable iff (rst_i)
		dc_wr && !dc_soft_reset_bit && state == other_drive_state |=>
		state == other_drive_state && h2d_o.valid && !h2d_o.command_flag)
		else $error("devctl frame while not selected wrong");
	diag_wake_a: assert property (@(posedge ref_clk_i) // [R16]
		disable iff (rst_i)
		cmd_wr && state == other_drive_state && wbyte == exec_diag_code
		|=> state == selected_quiet_state && h2d_o.valid &&
		h2d_o.command_flag && !shadow.device[drive_select_pos] &&
		!irq_pending_flag)
		else $error("diagnostic handling wrong");
	reselect_irq_a: assert property (@(posedge ref_clk_i) // [R17]
		disable iff (rst_i)
		dev_wr && !sel_one && state == other_drive_state &&
		irq_pending_flag && !shadow.control[interrupt_disable_pos]
		|=> state == selected_irq_state)
		else $error("reselect missed pending interrupt");
	reselect_quiet_a: assert property (@(posedge ref_clk_i) // [R17]
		disable iff (rst_i)
		dev_wr && !sel_one && state == other_drive_state &&
		!irq_pending_flag |=> state == selected_quiet_state)
		else $error("reselect raised without pending");
	notsel_write_a: assert property (@(posedge ref_clk_i) // [R18]
		disable iff (rst_i)
		other_acc && state == other_drive_state |=>
		state == other_drive_state && !h2d_o.valid)
		else $error("other write acted while not selected");
	notsel_status_a: assert property (@(posedge ref_clk_i) // [R19]
		disable iff (rst_i)
		psel_i && !penable_i && !pwrite_i &&
		state == other_drive_state && paddr_i == off_status_command
		|=> prdata_o == {24'h00_0000, not_selected_status})
		else $error("status read not zero while not selected");
	notsel_busy_a: assert property (@(posedge ref_clk_i) // [R15]
		disable iff (rst_i)
		cmd_wr && state == other_drive_state &&
		wbyte != exec_diag_code && !d2h_i.valid |=>
		shadow.status == $past(shadow.status))
		else $error("ignored command touched busy");
	reset_drive_a: assert property (@(posedge ref_clk_i) // [R12]
		disable iff (rst_i)
		cr_wr && state == other_drive_state |=>
		!shadow.device[drive_select_pos] &&
		shadow.status[busy_status_pos])
		else $error("comreset left drive 1 selected");

endmodule

// file: design/host_adapter_pkg.sv
package host_adapter_pkg;

	// apb byte offsets of the emulated task-file registers
	localparam logic [7:0] off_data = 8'h00;
	localparam logic [7:0] off_error_features = 8'h04;
	localparam logic [7:0] off_sector_count = 8'h08;
	localparam logic [7:0] off_lba_low = 8'h0c;
	localparam logic [7:0] off_lba_mid = 8'h10;
	localparam logic [7:0] off_lba_high = 8'h14;
	localparam logic [7:0] off_device = 8'h18;
	localparam logic [7:0] off_status_command = 8'h1c;
	localparam logic [7:0] off_altstat_devctl = 8'h20;
	localparam logic [7:0] off_comreset = 8'h24;
	localparam logic [7:0] off_adapter_state = 8'h28;

	// field positions
	localparam int drive_select_pos = 4;
	localparam int soft_reset_pos = 2;
	localparam int interrupt_disable_pos = 1;
	localparam int busy_status_pos = 7;

	localparam logic [7:0] exec_diag_code = 8'h90;
	localparam logic [7:0] not_selected_status = 8'h00;
	localparam logic [7:0] status_reset_value = 8'h80;
	localparam logic [7:0] zero_byte = 8'h00;

	typedef enum logic [1:0] {
		selected_quiet_state = 2'b00,
		selected_irq_state = 2'b01,
		other_drive_state = 2'b11
	} adapter_state_e;

	// shadow command and control blocks
	typedef struct packed {
		logic [7:0] features;
		logic [7:0] error;
		logic [7:0] sector_count;
		logic [7:0] lba_low;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
		logic [7:0] device;
		logic [7:0] status;
		logic [7:0] command;
		logic [7:0] control;
	} shadow_s;

	// host-to-device register frame request
	typedef struct packed {
		logic valid;
		logic command_flag;
		shadow_s blocks;
	} h2d_req_s;

	// device-to-host register content from the transport
	typedef struct packed {
		logic valid;
		logic irq_flag;
		logic [7:0] error;
		logic [7:0] sector_count;
		logic [7:0] lba_low;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
		logic [7:0] device;
		logic [7:0] status;
	} d2h_reg_s;

endpackage

// file: verif/host_adapter_device_select_emulation_bench.sv
`timescale 1ns/1ps
module host_adapter_device_select_emulation_bench;
	import host_adapter_pkg::*;
	logic ref_clk_i = 0;
	logic rst_i = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, comreset, err;
	d2h_reg_s d2h;
	h2d_req_s h2d, last;
	int frames, resets, fr;
	int num_errors = 0;
	int num_checks = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	host_adapter u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .d2h_i(d2h),
		.h2d_o(h2d), .comreset_o(comreset),
		.host_interrupt_line_o(irq));
	transport_model u_far (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.h2d_i(h2d), .comreset_i(comreset), .d2h_o(d2h),
		.frames_o(frames), .resets_o(resets), .last_o(last));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, d,
		output logic [7:0] r);
		@(posedge ref_clk_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk_i);
		penable <= 1;
		@(posedge ref_clk_i);
		while (pready !== 1'b1)
			@(posedge ref_clk_i);
		r = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		apb(1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		logic [7:0] r;
		apb(0, a, 8'h00, r);
		check(r, exp);
	endtask
	// state code, interrupt line and frames sent since the last look
	task automatic look(input logic [2:0] s, input int n, input logic c);
		rd(off_adapter_state, {5'h0, s});
		check(8'(irq), 8'(s[1:0] == 2'b01));
		check(8'(frames - fr), 8'(n));
		fr = frames;
		if (n > 0) begin
			check(8'(last.command_flag), 8'(c));
			check(8'(last.blocks.control[interrupt_disable_pos]), 8'h00);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		look(3'b000, 0, 0);
		rd(off_status_command, 8'h80);
		rd(8'h3c, 8'h00);
		check(8'(err), 8'h01);
		look(3'b000, 0, 0);
	endtask
	task automatic t_irq;
		u_far.send(1, 8'h2b);
		look(3'b101, 0, 0);
		rd(off_lba_mid, 8'h2b);
		wr(off_lba_low, 8'h11);
		look(3'b101, 0, 0);
		u_far.send(0, 8'h22);
		look(3'b101, 0, 0);
		rd(off_lba_high, 8'h22);
		wr(off_altstat_devctl, 8'h00);
		look(3'b101, 1, 0);
		rd(off_status_command, 8'h50);
		look(3'b000, 0, 0);
	endtask
	task automatic t_leave;
		u_far.send(1, 8'h2b);
		wr(off_status_command, 8'h25);
		look(3'b000, 1, 1);
		rd(off_status_command, 8'hd0);
		u_far.send(1, 8'h2b);
		wr(off_altstat_devctl, 8'h04);
		look(3'b000, 1, 0);
		rd(off_status_command, 8'hd0);
	endtask
	task automatic t_notsel;
		u_far.send(1, 8'h2b);
		wr(off_device, 8'h10);
		look(3'b111, 0, 0);
		rd(off_status_command, 8'h00);
		rd(off_altstat_devctl, 8'h00);
		rd(off_lba_mid, 8'h2b);
		u_far.send(0, 8'h44);
		look(3'b111, 0, 0);
		wr(off_lba_low, 8'h33);
		look(3'b111, 0, 0);
		wr(off_status_command, 8'h25);
		look(3'b111, 0, 0);
		wr(off_altstat_devctl, 8'h00);
		look(3'b111, 1, 0);
		check(last.blocks.device, 8'h44);
		check(last.blocks.lba_low, 8'h33);
		wr(off_device, 8'h00);
		look(3'b101, 0, 0);
		rd(off_status_command, 8'h50);
	endtask
	// diagnostic, soft reset and link reset out of the other drive state
	task automatic t_wake;
		logic [7:0] a[3] = '{off_status_command, off_altstat_devctl,
			off_comreset};
		logic [7:0] d[3] = '{exec_diag_code, 8'h04, 8'h00};
		for (int i = 0; i < 3; i++) begin
			u_far.send(1, 8'h2b);
			wr(off_device, 8'h10);
			wr(a[i], d[i]);
			look(3'b000, (i < 2), (i == 0));
			if (i < 2) begin
				check(last.blocks.device, 8'h00);
			end
			check(8'(resets), 8'(i == 2));
			rd(off_device, 8'h00);
			rd(off_status_command, 8'hd0);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		fr = 0;
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 0;
		t_reset;
		t_irq;
		t_leave;
		t_notsel;
		t_wake;
		finish_test;
	end
	// the whole sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		num_errors++;
		finish_test;
	end
endmodule

// file: verif/transport_model.sv
`timescale 1ns/1ps
module transport_model
	import host_adapter_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// adapter side
	input wire h2d_req_s h2d_i,
	input wire logic comreset_i,
	output d2h_reg_s d2h_o,
	// observation
	output int frames_o,
	output int resets_o,
	output h2d_req_s last_o
);
	initial d2h_o = '0;
	////////////////////////////////////////////////////////////////////////
	// pending is reported only through the irq flag
	task automatic send(input logic irq, input logic [7:0] b);
		@(posedge ref_clk_i);
		d2h_o <= {1'b1, irq, {6{b}}, 8'h50};
		@(posedge ref_clk_i);
		// idle bytes flip so stale content is never taken as new
		d2h_o <= {1'b0, ~irq, {6{~b}}, 8'haf};
	endtask
	////////////////////////////////////////////////////////////////////////
	// the drive never looks at the interrupt disable bit it receives
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frames_o <= 0;
			resets_o <= 0;
		end else begin
			if (h2d_i.valid === 1'b1) begin
				frames_o <= frames_o + 1;
				last_o <= h2d_i;
			end
			if (comreset_i === 1'b1)
				resets_o <= resets_o + 1;
		end
	end
endmodule
